// File: pkg/slrc_pkg.sv
// constants for the strap, led and reset control block
// assumes one 10 MHz clock and a classic wishbone register port
package slrc_pkg;

    // clock and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int RESET_TIME_US = 1000;
    localparam int RESET_CYCLES_DEF =
        RESET_TIME_US * (CLK_HZ / 1_000_000) + 1;
    localparam int BLINK10_HZ = 10;
    localparam int BLINK20_HZ = 20;
    localparam int HALF20_DEF = CLK_HZ / (2 * BLINK20_HZ);

    // register indexes, byte address is four times the index
    localparam logic [5:0] IDX_MAIN = 6'h00;
    localparam logic [5:0] IDX_ADV = 6'h04;
    localparam logic [5:0] IDX_TX100 = 6'h13;
    localparam logic [5:0] IDX_MODE = 6'h14;
    localparam logic [5:0] IDX_STRAP = 6'h18;
    localparam logic [5:0] IDX_STATUS = 6'h19;

    // main control bit positions
    localparam int MAIN_RESET_BIT = 15;
    localparam int MAIN_LOOP_BIT = 14;
    localparam int MAIN_SPEED_BIT = 13;
    localparam int MAIN_ANE_BIT = 12;
    localparam int MAIN_PDOWN_BIT = 11;
    localparam int MAIN_DUPLEX_BIT = 8;

    // other field positions
    localparam int TX100_MLT3_BIT = 1;
    localparam int ADV_LO_BIT = 5;
    localparam int MODE_LED_LO_BIT = 3;

    // reset values and writable masks
    localparam logic [15:0] MAIN_RST = 16'h2000;
    localparam logic [15:0] MAIN_WMASK = 16'h7900;
    localparam logic [15:0] ADV_RST = 16'h01E1;
    localparam logic [15:0] ADV_WMASK = 16'h01E0;
    localparam logic [15:0] TX100_RST = 16'h0000;
    localparam logic [15:0] TX100_WMASK = 16'h0002;

endpackage

// File: pkg/slrc_blink_if.sv
// blink enables passed from the divider to the led logic
// assumes both ends share clk_in
`timescale 1ns/1ns
`default_nettype none
interface slrc_blink_if;
    logic blink10;
    logic blink20;
    modport gen (output blink10, output blink20);
    modport use_side (input blink10, input blink20);
endinterface
`default_nettype wire

// File: hw/slrc_blink_gen.sv
// divider making the 10 Hz and 20 Hz led blink squares
// assumes clk_in at the package rate and a synchronous reset
`timescale 1ns/1ns
`default_nettype none
module slrc_blink_gen
    import slrc_pkg::*;
#(
    parameter int HALF20 = HALF20_DEF
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // blink squares
    slrc_blink_if.gen blink_port
);

    logic [17:0] cnt_q;
    logic b20_q;
    logic b10_q;
    logic wrap;

    assign wrap = (cnt_q == 18'(HALF20 - 1));

    ////////////////////////////////////////////////////////////////////
    // half period counter
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cnt_q <= 18'h00000;
        end else if (wrap) begin
            cnt_q <= 18'h00000;
        end else begin
            cnt_q <= cnt_q + 18'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // 20 Hz toggles each wrap, 10 Hz every second wrap
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            b20_q <= 1'b0;
            b10_q <= 1'b0;
        end else if (wrap) begin
            b20_q <= ~b20_q; // R21
            if (b20_q) begin
                b10_q <= ~b10_q; // R21
            end
        end
    end

    assign blink_port.blink20 = b20_q;
    assign blink_port.blink10 = b10_q;

endmodule
`default_nettype wire

// File: hw/slrc_top.sv
// strap capture, led drive, reset sequencing and power-down control
// assumes synchronous pins, one clock and a classic wishbone master
// How it works
// [R1] 10M led on at 10M speed; its strap lands in mode bit 7
// [R2] activity led blinks 10 Hz on traffic; strap in mode bit 6
// [R3] link led on while link good; strap lands in mode bit 5
// [R4] duplex led on at full duplex; strap lands in mode bit 4
// [R5] at half duplex the duplex led blinks 20 Hz on collision
// [R6] 100M led on at 100M speed; its strap lands in mode bit 3
// [R7] autoneg on (multifunc 0 strap): advertise from both configs
// [R8] autoneg off: config a sets mlt3 bypass bit 1 of tx100 reg
// [R9] autoneg off: config b sets loopback bit 14
// [R10] board holds reset low at least 1 ms
// [R11] reset sequence always runs and lasts more than 1 ms
// [R12] reset-in-progress low until sequence done, then high
// [R13] power-down is pin OR control bit 11
// [R14] power-down floats leds and isolates line and mii; this block only floats the leds, it has no line or mii isolation
// [R15] control bits take strap levels when reset completes
// [R16] multifunc 0 chooses meaning of configs and fde
// [R17] autoneg on: full duplex advertisement from fde and configs
// [R18] autoneg off: fde sets duplex bit 8
// [R19] autoneg off: advertisement bits 5..8 keep defaults
// [R20] led active high if strap low, active low if strap high
// [R21] blink rates are counted from the block clock
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module slrc_top
    import slrc_pkg::*;
#(
    parameter int RESET_CYCLES = RESET_CYCLES_DEF,
    parameter int BLINK_HALF20 = HALF20_DEF
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,

    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,

    // line status from the transceiver core
    input wire logic speed10_in,
    input wire logic speed100_in,
    input wire logic link_good_in,
    input wire logic activity_in,
    input wire logic collision_in,

    // configuration pins
    input wire logic [4:0] multifunc_in,
    input wire logic config_in_a,
    input wire logic config_in_b,
    input wire logic fde_in,
    input wire logic pwrdwn_in,

    // led pins doubling as straps, bit 4 is speed10_led
    input wire logic [4:0] led_in,
    output logic [4:0] led_out,
    output logic [4:0] led_oe_n_out,

    // reset and power state
    output logic rip_out,
    output logic power_down_out
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [15:0] merge(
        input logic [15:0] old_v,
        input logic [15:0] new_v,
        input logic [15:0] mask
    );
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    function automatic logic [15:0] lanes(input logic [3:0] sel);
        lanes = {{8{sel[1]}}, {8{sel[0]}}};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic [15:0] main_q;
    logic [15:0] adv_q;
    logic [15:0] tx100_q;
    logic [4:0] mode_q;
    logic [7:0] strap_q;
    logic [13:0] rst_cnt_q;
    logic in_reset_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [4:0] led_q;
    logic [4:0] oe_n_q;
    logic rip_q;
    logic pd_q;

    logic req;
    logic wr_en;
    logic [5:0] idx;
    logic [15:0] wmask;
    logic sw_rst;
    logic done;
    logic pd_d;
    logic ane_pin;
    logic [4:0] led_on;
    logic [15:0] main_strap;
    logic [15:0] adv_strap;
    logic [15:0] tx100_strap;
    logic [15:0] rd_word;

    slrc_blink_if blink_bus ();

    ////////////////////////////////////////////////////////////////////
    // blink divider

    slrc_blink_gen #(
        .HALF20(BLINK_HALF20)
    ) u_blink (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .blink_port(blink_bus.gen)
    );

    ////////////////////////////////////////////////////////////////////
    // bus decode

    assign req = wb_cyc_in & wb_stb_in;
    assign idx = wb_adr_in[7:2];
    assign wr_en = req & wb_we_in & ack_q & ~in_reset_q;
    assign wmask = lanes(wb_sel_in);
    assign sw_rst = wr_en & (idx == IDX_MAIN) & wb_sel_in[1]
        & wb_dat_in[MAIN_RESET_BIT];

    ////////////////////////////////////////////////////////////////////
    // reset sequence

    assign done = in_reset_q & (rst_cnt_q == 14'(RESET_CYCLES - 1));

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            in_reset_q <= 1'b1; // R11
            rst_cnt_q <= 14'h0000;
        end else if (sw_rst) begin
            in_reset_q <= 1'b1;
            rst_cnt_q <= 14'h0000;
        end else if (done) begin
            in_reset_q <= 1'b0; // R11
        end else if (in_reset_q) begin
            rst_cnt_q <= rst_cnt_q + 14'h0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rip_q <= 1'b0;
        end else begin
            rip_q <= ~in_reset_q; // R12
        end
    end

    ////////////////////////////////////////////////////////////////////
    // strap decode

    assign ane_pin = multifunc_in[0]; // R16

    always_comb begin
        main_strap = MAIN_RST;
        main_strap[MAIN_ANE_BIT] = ane_pin; // R15
        main_strap[MAIN_LOOP_BIT] = ~ane_pin & config_in_b; // R9
        main_strap[MAIN_DUPLEX_BIT] = ~ane_pin & fde_in; // R18
    end

    always_comb begin
        adv_strap = ADV_RST; // R19
        if (ane_pin) begin
            adv_strap[ADV_LO_BIT + 3] = config_in_a & fde_in; // R17
            adv_strap[ADV_LO_BIT + 2] = config_in_a; // R7
            adv_strap[ADV_LO_BIT + 1] = config_in_b & fde_in; // R17
            adv_strap[ADV_LO_BIT] = config_in_b; // R7
        end
    end

    always_comb begin
        tx100_strap = TX100_RST;
        tx100_strap[TX100_MLT3_BIT] = ~ane_pin & config_in_a; // R8
    end

    ////////////////////////////////////////////////////////////////////
    // main control register

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            main_q <= MAIN_RST;
        end else if (done) begin
            main_q <= main_strap; // R15
        end else if (wr_en && idx == IDX_MAIN) begin
            main_q <= merge(main_q, wb_dat_in[15:0], MAIN_WMASK & wmask);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // advertisement register

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            adv_q <= ADV_RST;
        end else if (done) begin
            adv_q <= adv_strap; // R7
        end else if (wr_en && idx == IDX_ADV) begin
            adv_q <= merge(adv_q, wb_dat_in[15:0], ADV_WMASK & wmask);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // tx100 control register

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            tx100_q <= TX100_RST;
        end else if (done) begin
            tx100_q <= tx100_strap; // R8
        end else if (wr_en && idx == IDX_TX100) begin
            tx100_q <= merge(tx100_q, wb_dat_in[15:0],
                TX100_WMASK & wmask);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // strap capture, leds float during reset so straps are readable

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            mode_q <= 5'h00;
            strap_q <= 8'h00;
        end else if (done) begin
            mode_q <= led_in; // R1 R2 R3 R4 R6
            strap_q <= {fde_in, config_in_b, config_in_a, multifunc_in};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // led drive

    always_comb begin
        led_on[4] = speed10_in; // R1
        led_on[3] = activity_in & blink_bus.blink10; // R2
        led_on[2] = link_good_in; // R3
        led_on[1] = main_q[MAIN_DUPLEX_BIT] // R4
            | (collision_in & blink_bus.blink20); // R5
        led_on[0] = speed100_in; // R6
    end

    assign pd_d = pwrdwn_in | main_q[MAIN_PDOWN_BIT]; // R13

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            led_q <= 5'h00;
        end else begin
            led_q <= led_on ^ mode_q; // R20
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            oe_n_q <= 5'h1F;
            pd_q <= 1'b0;
        end else begin
            oe_n_q <= {5{pd_d | in_reset_q}}; // R14
            pd_q <= pd_d; // R13
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus answer, one wait state, unmapped reads give zero

    always_comb begin
        rd_word = 16'h0000;
        unique case (idx)
            IDX_MAIN: rd_word = main_q;
            IDX_ADV: rd_word = adv_q;
            IDX_TX100: rd_word = tx100_q;
            IDX_MODE: rd_word = {8'h00, mode_q, 3'h0};
            IDX_STRAP: rd_word = {8'h00, strap_q};
            IDX_STATUS: rd_word = {9'h000, led_on, pd_q, rip_q};
            default: rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= req & ~ack_q;
            if (req && !ack_q) begin
                dat_q <= {16'h0000, rd_word};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign wb_ack_out = ack_q;
    assign wb_dat_out = dat_q;
    assign led_out = led_q;
    assign led_oe_n_out = oe_n_q;
    assign rip_out = rip_q;
    assign power_down_out = pd_q;

    ////////////////////////////////////////////////////////////////////
    // checks

    AST_RESET_LEN: assert property (@(posedge clk_in) // R11
        disable iff (!reset_n_in)
        $fell(in_reset_q) |-> $past(rst_cnt_q) == 14'(RESET_CYCLES - 1))
        else $error("reset sequence ended at wrong count");

    AST_RIP_LOW: assert property (@(posedge clk_in) // R12
        disable iff (!reset_n_in)
        in_reset_q |=> !rip_out)
        else $error("rip high during reset sequence");

    AST_RIP_RISE: assert property (@(posedge clk_in) // R12
        disable iff (!reset_n_in)
        $fell(in_reset_q) |-> !rip_out ##1 rip_out)
        else $error("rip did not rise after reset");

    AST_PD_OR: assert property (@(posedge clk_in) // R13
        disable iff (!reset_n_in)
        (pwrdwn_in || main_q[MAIN_PDOWN_BIT]) |=> power_down_out)
        else $error("power-down not entered");

    AST_PD_FLOAT: assert property (@(posedge clk_in) // R14
        disable iff (!reset_n_in)
        power_down_out |-> led_oe_n_out == 5'h1F)
        else $error("led driven in power-down");

    AST_STRAP_CAP: assert property (@(posedge clk_in) // R1
        disable iff (!reset_n_in)
        $fell(in_reset_q) |-> mode_q == $past(led_in))
        else $error("led straps not captured");

    AST_MLT3: assert property (@(posedge clk_in) // R8
        disable iff (!reset_n_in)
        $fell(in_reset_q) && !$past(multifunc_in[0])
        |-> tx100_q[TX100_MLT3_BIT] == $past(config_in_a))
        else $error("mlt3 bypass bit wrong");

    AST_LOOP: assert property (@(posedge clk_in) // R9
        disable iff (!reset_n_in)
        $fell(in_reset_q) && !$past(multifunc_in[0])
        |-> main_q[MAIN_LOOP_BIT] == $past(config_in_b))
        else $error("loopback bit wrong");

    AST_FDX: assert property (@(posedge clk_in) // R18
        disable iff (!reset_n_in)
        $fell(in_reset_q) && !$past(multifunc_in[0])
        |-> main_q[MAIN_DUPLEX_BIT] == $past(fde_in))
        else $error("duplex bit wrong");

    AST_ADV_ON: assert property (@(posedge clk_in) // R17
        disable iff (!reset_n_in)
        $fell(in_reset_q) && $past(multifunc_in[0])
        |-> adv_q[8:5] == {$past(config_in_a) & $past(fde_in),
            $past(config_in_a), $past(config_in_b) & $past(fde_in),
            $past(config_in_b)})
        else $error("advertisement bits wrong");

    AST_ADV_OFF: assert property (@(posedge clk_in) // R19
        disable iff (!reset_n_in)
        $fell(in_reset_q) && !$past(multifunc_in[0])
        |-> adv_q == ADV_RST)
        else $error("advertisement not default");

    AST_LED_POL: assert property (@(posedge clk_in) // R20
        disable iff (!reset_n_in)
        rip_out |=> led_out[0] == ($past(speed100_in) ^ mode_q[0]))
        else $error("100M led polarity wrong");

    AST_COL_BLINK: assert property (@(posedge clk_in) // R5
        disable iff (!reset_n_in)
        (rip_out && !main_q[MAIN_DUPLEX_BIT] && collision_in)
        |=> led_out[1] == ($past(blink_bus.blink20) ^ mode_q[1]))
        else $error("collision blink wrong");

endmodule
`default_nettype wire

// File: testbench/slrc_board.sv
// board model: strap resistors on the led pins and the reset driver
// assumes led pins are released while the output enable is high
`timescale 1ns/1ns
`default_nettype none
module slrc_board #(
    parameter int HOLD = 10
) (
    // clock and reset request
    input wire logic clk_in,
    input wire logic go_in,
    // strap levels and led drive from the block
    input wire logic [4:0] strap_in,
    input wire logic [4:0] led_in,
    input wire logic [4:0] led_oe_n_in,
    // board side levels
    output logic reset_n_out,
    output logic [4:0] pin_out,
    output logic [4:0] lit_out
);
    int cnt = HOLD;

    ////////////////////////////////////////////////////////////////////
    // reset held low for a full hold time after each request
    always @(posedge clk_in) begin
        if (go_in) begin
            cnt <= HOLD;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    assign reset_n_out = (cnt == 0);

    ////////////////////////////////////////////////////////////////////
    // released pin rests at its strap level, lit when driven off it
    assign pin_out = (led_oe_n_in & strap_in) | (~led_oe_n_in & led_in);
    assign lit_out = ~led_oe_n_in & (pin_out ^ strap_in);
endmodule
`default_nettype wire

// File: testbench/strap_led_reset_control_test.sv
// self-checking bench for the strap, led and reset control block
// assumes the board model and the design package constants
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module strap_led_reset_control_test;
    import slrc_pkg::*;
    localparam int RC = 20;
    localparam int BH = 4;
    logic clk_in = 1'b0;
    logic go = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic sp10 = 1'b0;
    logic sp100 = 1'b0;
    logic link = 1'b0;
    logic act = 1'b0;
    logic coll = 1'b0;
    logic [4:0] mf = 5'h00;
    logic cfa = 1'b0;
    logic cfb = 1'b0;
    logic fde = 1'b0;
    logic pdn = 1'b0;
    logic [4:0] strap = 5'h00;
    logic reset_n, ack, rip, pd;
    logic [31:0] rdat;
    logic [4:0] pin, led_q, oe_n, lit;
    int n_mismatch = 0;
    int cmp_count = 0;

    initial forever #50 clk_in = ~clk_in;

    slrc_top #(.RESET_CYCLES(RC), .BLINK_HALF20(BH)) DUT (
        .clk_in(clk_in), .reset_n_in(reset_n),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(4'h3), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .speed10_in(sp10), .speed100_in(sp100),
        .link_good_in(link), .activity_in(act), .collision_in(coll),
        .multifunc_in(mf), .config_in_a(cfa), .config_in_b(cfb),
        .fde_in(fde), .pwrdwn_in(pdn), .led_in(pin), .led_out(led_q),
        .led_oe_n_out(oe_n), .rip_out(rip), .power_down_out(pd));

    slrc_board #(.HOLD(10)) board (
        .clk_in(clk_in), .go_in(go), .strap_in(strap), .led_in(led_q),
        .led_oe_n_in(oe_n), .reset_n_out(reset_n), .pin_out(pin),
        .lit_out(lit));

    ////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wb(input logic w, input logic [5:0] idx,
                      input logic [15:0] d, output logic [15:0] q);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            test_done();
        end
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic wait_rip(output int n);
        n = 0;
        while (reset_n !== 1'b1 && n < 100) begin
            @(posedge clk_in);
            n++;
        end
        n = 0;
        while (rip !== 1'b1 && n < 100) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 100) begin
            n_mismatch++;
            test_done();
        end
    endtask

    task automatic do_reset(input logic [4:0] m, input logic a,
                            input logic b, input logic f,
                            input logic [4:0] s);
        int n;
        mf <= m;
        cfa <= a;
        cfb <= b;
        fde <= f;
        strap <= s;
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        repeat (3) @(posedge clk_in);
        `CHK({rip, oe_n}, 6'h1F);
        wait_rip(n);
        `CHK(n >= RC && n <= RC + 2, 1'b1);
    endtask

    task automatic count_toggles(input int b, output int n);
        logic p;
        repeat (3) @(posedge clk_in);
        p = lit[b];
        n = 0;
        repeat (64) begin
            @(posedge clk_in);
            if (lit[b] !== p) n++;
            p = lit[b];
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_disabled();
        logic [15:0] q;
        logic [4:0] s;
        logic [4:0] dup;
        for (int i = 0; i < 2; i++) begin
            s = 5'h16 ^ {5{i[0]}};
            dup = {3'h0, i[0], 1'b0};
            do_reset(5'h00, i[0], i[0], i[0], s);
            wb(1'b0, IDX_MAIN, 16'h0000, q);
            `CHK(q & MAIN_WMASK, {1'b0, i[0], 5'h10, i[0], 8'h00});
            wb(1'b0, IDX_TX100, 16'h0000, q);
            `CHK(q[TX100_MLT3_BIT], i[0]);
            wb(1'b0, IDX_ADV, 16'h0000, q);
            `CHK(q, ADV_RST);
            wb(1'b0, IDX_MODE, 16'h0000, q);
            `CHK(q[7:3], s);
            sp10 <= 1'b1;
            link <= 1'b1;
            repeat (3) @(posedge clk_in);
            `CHK(lit, 5'h14 | dup);
            `CHK(oe_n, 5'h00);
            sp10 <= 1'b0;
            link <= 1'b0;
            sp100 <= 1'b1;
            repeat (3) @(posedge clk_in);
            `CHK(lit, 5'h01 | dup);
            sp100 <= 1'b0;
        end
        $display("test disabled autoneg done");
    endtask

    task automatic t_autoneg();
        logic [15:0] q;
        for (int i = 0; i < 8; i++) begin
            do_reset(5'h01, i[0], i[1], i[2], 5'h00);
            wb(1'b0, IDX_ADV, 16'h0000, q);
            `CHK(q[8:5], {i[0] & i[2], i[0], i[1] & i[2], i[1]});
            wb(1'b0, IDX_MAIN, 16'h0000, q);
            `CHK(q & MAIN_WMASK, 16'h3000);
        end
        $display("test autoneg done");
    endtask

    task automatic t_blink();
        logic [15:0] q;
        int n;
        do_reset(5'h00, 1'b0, 1'b0, 1'b1, 5'h0B);
        act <= 1'b1;
        count_toggles(3, n);
        `CHK(n >= 7 && n <= 9, 1'b1);
        act <= 1'b0;
        coll <= 1'b1;
        count_toggles(1, n);
        `CHK({n[7:0], lit[1]}, 9'h001);
        wb(1'b1, IDX_MAIN, 16'h2000, q);
        count_toggles(1, n);
        `CHK(n >= 15 && n <= 17, 1'b1);
        coll <= 1'b0;
        $display("test blink done");
    endtask

    task automatic t_pdown();
        logic [15:0] q;
        pdn <= 1'b1;
        repeat (3) @(posedge clk_in);
        `CHK({pd, oe_n}, 6'h3F);
        pdn <= 1'b0;
        repeat (3) @(posedge clk_in);
        `CHK({pd, oe_n}, 6'h00);
        wb(1'b1, IDX_MAIN, 16'h2800, q);
        repeat (2) @(posedge clk_in);
        `CHK({pd, oe_n}, 6'h3F);
        wb(1'b1, IDX_MAIN, 16'h2000, q);
        repeat (2) @(posedge clk_in);
        `CHK(pd, 1'b0);
        $display("test power down done");
    endtask

    task automatic t_bus();
        logic [15:0] q;
        int n;
        wb(1'b1, 6'h30, 16'hFFFF, q);
        wb(1'b0, 6'h30, 16'h0000, q);
        `CHK(q, 16'h0000);
        wb(1'b1, IDX_MODE, 16'h0000, q);
        wb(1'b0, IDX_MODE, 16'h0000, q);
        `CHK(q[7:3], 5'h0B);
        wb(1'b1, IDX_MAIN, 16'hA000, q);
        @(posedge clk_in);
        `CHK(rip, 1'b0);
        wb(1'b1, IDX_MAIN, 16'h2800, q);
        wait_rip(n);
        wb(1'b0, IDX_MAIN, 16'h0000, q);
        `CHK(q & MAIN_WMASK, 16'h2100);
        `CHK(pd, 1'b0);
        wb(1'b0, IDX_STRAP, 16'h0000, q);
        `CHK(q, 16'h0080);
        wb(1'b0, IDX_STATUS, 16'h0000, q);
        `CHK(q, 16'h0009);
        $display("test bus done");
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        t_disabled();
        t_autoneg();
        t_blink();
        t_pdown();
        t_bus();
        test_done();
    end
endmodule
`default_nettype wire
